// [hdl/dmr_mem_if.sv]
// carrier between the readback bank and its result store.
// assumes one clock; write and read share no ordering beyond the edge.
`timescale 1ns/100ps
`default_nettype none
interface dmr_mem_if;
    import dmr_pkg::*;
    logic wr_en;
    logic [DMR_IW-1:0] wr_idx;
    logic [DMR_RW-1:0] wr_data;
    logic rd_en;
    logic [DMR_IW-1:0] rd_idx;
    logic [DMR_RW-1:0] rd_data;

    modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data);
    modport store (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data);
endinterface : dmr_mem_if
`default_nettype wire

// [hdl/dmr_pkg.sv]
// register map, field positions, reset values and channel codes of the
// diagnostic monitor readback bank.
// assumes an 8-bit device register port and 12-bit converter results.
package dmr_pkg;
    // widths
    localparam int DMR_AW = 8;
    localparam int DMR_DW = 8;
    localparam int DMR_RW = 12;
    localparam int DMR_CW = 4;
    localparam int DMR_SLOTS = 7;
    localparam int DMR_IW = 3;

    // control register and its fields
    localparam logic [7:0] DMR_OFS_CTRL = 8'h55;
    localparam logic [7:0] DMR_CTRL_RESET = 8'h00;
    localparam int DMR_BIT_FREEZE = 0;
    localparam int DMR_BIT_SUBST = 1;
    localparam int DMR_BIT_AUX_FREEZE = 2;
    localparam int DMR_BIT_ROUTE = 3;
    localparam int DMR_CTRL_USED = 4;

    // result split: high byte is result[11:4], low nibble sits in [7:4]
    localparam int DMR_HI_LSB = 4;
    localparam int DMR_NIB_LSB = 4;
    localparam logic [11:0] DMR_RESULT_RESET = 12'h000;

    // per slot: high offset, low offset, fixed channel code
    // slot order: bias level, a pos, a neg, b pos, b neg, die heat, bias current
    localparam logic [7:0] DMR_OFS_HI [DMR_SLOTS] =
        '{8'h58, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6a, 8'h6c};
    localparam logic [7:0] DMR_OFS_LO [DMR_SLOTS] =
        '{8'h59, 8'h63, 8'h65, 8'h67, 8'h69, 8'h6b, 8'h6d};
    localparam logic [3:0] DMR_CODE [DMR_SLOTS] =
        '{4'h1, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
    localparam logic [2:0] DMR_SLOT_TEMP = 3'h5;

    // answer on an unmapped read
    localparam logic [7:0] DMR_RD_UNMAPPED = 8'h00;
endpackage : dmr_pkg

// [hdl/dmr_readback_bank.sv]
// diagnostic monitor readback bank: control register and result registers.
// assumes converter results arrive on this clock as one-cycle strobes.
//
// Contract
// R1 - while the converter freeze bit is 1 converter results stop updating, else they refresh.
// R2 - while the aux freeze bit is 1 aux converter data stop updating, else they refresh.
// R3 - the route bit set places aux converter data into the monitor result registers.
// R4 - the substitute bit set enables the temperature value override, clear disables it.
// R5 - control bits 7 to 4 read zero and all four control bits reset to 0.
// R6 - each high register shows result bits 11 to 4, read-only, reset zero.
// R7 - each low register shows result bits 3 to 0 in bits 7 to 4, read-only, reset zero.
// R8 - bias level sits at 0x58 and 0x59 with channel code 0001b.
// R9 - output a positive sits at 0x62 and 0x63 with channel code 0110b.
// R10 - output a negative sits at 0x64 and 0x65 with channel code 0111b.
// R11 - output b positive sits at 0x66 and 0x67 with channel code 1000b.
// R12 - output b negative sits at 0x68 and 0x69 with channel code 1001b.
// R13 - die temperature sits at 0x6a and 0x6b with channel code 1010b.
// R14 - bias load current sits at 0x6c and 0x6d with channel code 1011b.
// R15 - byte and nibble freeze together and updating resumes with the next result.
// R16 - software freezes, reads both halves, then releases the freeze bit.
`timescale 1ns/100ps
`default_nettype none
module dmr_readback_bank (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // device register port
    input wire logic [dmr_pkg::DMR_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [dmr_pkg::DMR_DW-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [dmr_pkg::DMR_DW-1:0] reg_rdata,
    output logic reg_rvalid,
    // main converter results
    input wire logic conv_valid,
    input wire logic [dmr_pkg::DMR_CW-1:0] conv_channel,
    input wire logic [dmr_pkg::DMR_RW-1:0] conv_data,
    // auxiliary converter results
    input wire logic aux_valid,
    input wire logic [dmr_pkg::DMR_CW-1:0] aux_channel,
    input wire logic [dmr_pkg::DMR_RW-1:0] aux_data,
    // temperature substitute value
    input wire logic [dmr_pkg::DMR_RW-1:0] temp_substitute_data,
    // control state towards the analog side
    output logic freeze_converter_readback,
    output logic temperature_value_substitute,
    output logic freeze_aux_converter_readback,
    output logic route_aux_converter_to_monitor
);
    import dmr_pkg::*;

    dmr_mem_if mem_if ();

    logic [DMR_SLOTS-1:0] hit_hi;
    logic [DMR_SLOTS-1:0] hit_lo;
    logic [DMR_SLOTS-1:0] code_hit;
    logic hit_ctrl;
    logic [DMR_IW-1:0] rd_slot;
    logic [DMR_IW-1:0] src_slot;
    logic src_known;
    logic src_valid;
    logic [DMR_CW-1:0] src_channel;
    logic [DMR_RW-1:0] src_data;
    logic src_frozen;
    logic rd_pend;
    logic rd_was_lo;
    logic rd_was_ctrl;
    logic rd_was_map;
    logic [DMR_IW-1:0] rd_slot_q;

    // address and channel decode, one comparator set per slot
    for (genvar s = 0; s < DMR_SLOTS; s++) begin : g_slot
        assign hit_hi[s] = (reg_addr == DMR_OFS_HI[s]);
        assign hit_lo[s] = (reg_addr == DMR_OFS_LO[s]);
        assign code_hit[s] = (src_channel == DMR_CODE[s]);
    end
    assign hit_ctrl = (reg_addr == DMR_OFS_CTRL);

    // one-hot to index for register reads and incoming results
    always_comb begin
        rd_slot = '0;
        src_slot = '0;
        for (int i = 0; i < DMR_SLOTS; i++) begin
            if (hit_hi[i] || hit_lo[i]) begin
                rd_slot = DMR_IW'(i);
            end
            if (code_hit[i]) begin
                src_slot = DMR_IW'(i);
            end
        end
    end
    assign src_known = |code_hit;

    // control register; reserved upper bits are never stored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            freeze_converter_readback <= DMR_CTRL_RESET[DMR_BIT_FREEZE]; // R5
            temperature_value_substitute <= DMR_CTRL_RESET[DMR_BIT_SUBST]; // R5
            freeze_aux_converter_readback <= DMR_CTRL_RESET[DMR_BIT_AUX_FREEZE]; // R5
            route_aux_converter_to_monitor <= DMR_CTRL_RESET[DMR_BIT_ROUTE]; // R5
        end else if (clk_en && reg_wr && hit_ctrl) begin
            freeze_converter_readback <= reg_wdata[DMR_BIT_FREEZE]; // R1
            temperature_value_substitute <= reg_wdata[DMR_BIT_SUBST]; // R4
            freeze_aux_converter_readback <= reg_wdata[DMR_BIT_AUX_FREEZE]; // R2
            route_aux_converter_to_monitor <= reg_wdata[DMR_BIT_ROUTE]; // R3
        end
    end

    // source select: route bit picks aux or main results and the matching freeze
    always_comb begin
        if (route_aux_converter_to_monitor) begin // R3
            src_valid = aux_valid;
            src_channel = aux_channel;
            src_data = aux_data;
            src_frozen = freeze_aux_converter_readback; // R2
        end else begin
            src_valid = conv_valid;
            src_channel = conv_channel;
            src_data = conv_data;
            src_frozen = freeze_converter_readback; // R1
        end
    end

    // store write; a frozen source writes nothing so byte and nibble stay paired
    // while the substitute bit is set, the substitute value refreshes the temperature slot whenever the source is not frozen and no result lands
    always_comb begin
        mem_if.wr_en = 1'b0;
        mem_if.wr_idx = src_slot;
        mem_if.wr_data = src_data;
        if (!src_frozen) begin // R1 R2 R15
            if (src_valid && src_known) begin
                mem_if.wr_en = 1'b1;
                if (temperature_value_substitute && src_slot == DMR_SLOT_TEMP) begin
                    mem_if.wr_data = temp_substitute_data; // R4
                end
            end else if (temperature_value_substitute) begin // R4
                mem_if.wr_en = 1'b1;
                mem_if.wr_idx = DMR_SLOT_TEMP;
                mem_if.wr_data = temp_substitute_data;
            end
        end
    end

    // read request into the store; the answer follows two edges later
    assign mem_if.rd_en = reg_rd && (|hit_hi || |hit_lo);
    assign mem_if.rd_idx = rd_slot;

    // read bookkeeping for the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_pend <= 1'b0;
            rd_was_lo <= 1'b0;
            rd_was_ctrl <= 1'b0;
            rd_was_map <= 1'b0;
            rd_slot_q <= '0;
        end else if (clk_en) begin
            rd_pend <= reg_rd;
            rd_was_lo <= |hit_lo;
            rd_was_ctrl <= hit_ctrl;
            rd_was_map <= |hit_hi || |hit_lo;
            rd_slot_q <= rd_slot;
        end
    end

    // read data; result registers are read-only and writes to them vanish
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= DMR_RD_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= rd_pend;
            if (rd_pend) begin
                if (rd_was_ctrl) begin
                    reg_rdata <= {4'h0, route_aux_converter_to_monitor, // R5
                                  freeze_aux_converter_readback,
                                  temperature_value_substitute,
                                  freeze_converter_readback};
                end else if (rd_was_map && rd_was_lo) begin
                    // nibble over fixed code
                    reg_rdata <= {mem_if.rd_data[DMR_NIB_LSB-1:0], // R7
                                  DMR_CODE[rd_slot_q]}; // R8 R9 R10 R11 R12 R13 R14
                end else if (rd_was_map) begin
                    reg_rdata <= mem_if.rd_data[DMR_RW-1:DMR_HI_LSB]; // R6
                end else begin
                    reg_rdata <= DMR_RD_UNMAPPED;
                end
            end
        end
    end

    dmr_result_store #(
        .DEPTH(DMR_SLOTS)
    ) u_store (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .mem(mem_if)
    );

    // helper: last value written to each slot's view, for read checks
    logic [DMR_RW-1:0] shadow [DMR_SLOTS];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DMR_SLOTS; i++) begin
                shadow[i] <= DMR_RESULT_RESET;
            end
        end else if (clk_en && mem_if.wr_en) begin
            shadow[mem_if.wr_idx] <= mem_if.wr_data;
        end
    end

    sequence s_read_issue;
        reg_rd && clk_en;
    endsequence

    sequence s_answer_two;
        clk_en ##1 clk_en ##0 reg_rvalid;
    endsequence

    a_read_latency: assert property (@(posedge clk) disable iff (!reset_n)
        s_read_issue |=> s_answer_two)
        else $error("read answer not two enabled edges after request");

    a_main_freeze_hold: assert property (@(posedge clk) disable iff (!reset_n) // R1
        (!route_aux_converter_to_monitor && freeze_converter_readback) |-> !mem_if.wr_en)
        else $error("store written while converter freeze set");

    a_aux_freeze_hold: assert property (@(posedge clk) disable iff (!reset_n) // R2
        (route_aux_converter_to_monitor && freeze_aux_converter_readback) |-> !mem_if.wr_en)
        else $error("store written while aux freeze set");

    a_aux_route_data: assert property (@(posedge clk) disable iff (!reset_n) // R3
        (route_aux_converter_to_monitor && !freeze_aux_converter_readback && aux_valid
         && src_known && !(temperature_value_substitute && src_slot == DMR_SLOT_TEMP))
        |-> mem_if.wr_en && mem_if.wr_data == aux_data)
        else $error("aux result not routed into monitor store");

    a_temp_substitute: assert property (@(posedge clk) disable iff (!reset_n) // R4
        (mem_if.wr_en && mem_if.wr_idx == DMR_SLOT_TEMP && temperature_value_substitute)
        |-> mem_if.wr_data == temp_substitute_data)
        else $error("temperature slot not taking substitute value");

    a_ctrl_reserved: assert property (@(posedge clk) disable iff (!reset_n) // R5
        (clk_en && reg_rd && hit_ctrl) ##1 clk_en |=> reg_rdata[7:4] == 4'h0)
        else $error("control reserved bits read nonzero");

    a_lo_code_fixed: assert property (@(posedge clk) disable iff (!reset_n) // R7
        (clk_en && rd_pend && rd_was_map && rd_was_lo)
        |=> reg_rdata[3:0] == DMR_CODE[$past(rd_slot_q)])
        else $error("low register channel code wrong");

    a_hi_byte_value: assert property (@(posedge clk) disable iff (!reset_n) // R6
        (clk_en && reg_rd && |hit_hi && !mem_if.wr_en) ##1 (clk_en && !mem_if.wr_en)
        |=> reg_rdata == shadow[$past(rd_slot_q)][DMR_RW-1:DMR_HI_LSB])
        else $error("high register byte not from stored result");

    // a released freeze, then the first result one cycle later
    // (a write and a strobe never share a cycle on the register port side)
    sequence s_freeze_release;
        $fell(src_frozen);
    endsequence

    sequence s_result_next;
        clk_en && src_valid && src_known && !src_frozen;
    endsequence

    a_resume_update: assert property (@(posedge clk) disable iff (!reset_n) // R15
        s_freeze_release ##1 s_result_next |-> mem_if.wr_en)
        else $error("update not resumed after freeze released");

    // read answer strobe drops when nothing is pending
    a_rvalid_idle: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && !rd_pend) |=> !reg_rvalid)
        else $error("read answer without pending read");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && rd_pend && !rd_was_map && !rd_was_ctrl) |=> reg_rdata == DMR_RD_UNMAPPED)
        else $error("unmapped read not answered with zero");

    // control bits take the written nibble and hold otherwise
    a_ctrl_write: assert property (@(posedge clk) disable iff (!reset_n) // R1 R2 R3 R4
        (clk_en && reg_wr && hit_ctrl) |=> {route_aux_converter_to_monitor,
        freeze_aux_converter_readback, temperature_value_substitute,
        freeze_converter_readback} == $past(reg_wdata[DMR_CTRL_USED-1:0]))
        else $error("control bits not taken from write");

    a_ctrl_steady: assert property (@(posedge clk) disable iff (!reset_n) // R1 R2 R3 R4
        !(clk_en && reg_wr && hit_ctrl) |=> $stable({route_aux_converter_to_monitor,
        freeze_aux_converter_readback, temperature_value_substitute,
        freeze_converter_readback}))
        else $error("control bits changed without a write");

    a_ctrl_readback: assert property (@(posedge clk) disable iff (!reset_n) // R5
        (clk_en && rd_pend && rd_was_ctrl) |=> reg_rdata[3:0] == $past({
        route_aux_converter_to_monitor, freeze_aux_converter_readback,
        temperature_value_substitute, freeze_converter_readback}))
        else $error("control readback differs from control bits");

    // a low enable must leave the answer path untouched
    a_enable_stall: assert property (@(posedge clk) disable iff (!reset_n)
        !clk_en |=> $stable(reg_rdata) && $stable(reg_rvalid) && $stable(rd_pend))
        else $error("state moved while clock enable low");

    a_main_route_data: assert property (@(posedge clk) disable iff (!reset_n) // R1
        (!route_aux_converter_to_monitor && !freeze_converter_readback && conv_valid
         && src_known && !(temperature_value_substitute && src_slot == DMR_SLOT_TEMP))
        |-> mem_if.wr_en && mem_if.wr_data == conv_data)
        else $error("main result not written into monitor store");

    // results on channels without a slot are dropped, not aliased
    a_unknown_dropped: assert property (@(posedge clk) disable iff (!reset_n)
        (src_valid && !src_known && !temperature_value_substitute) |-> !mem_if.wr_en)
        else $error("result with unmapped channel written");

    a_lo_nibble_value: assert property (@(posedge clk) disable iff (!reset_n) // R7
        (clk_en && reg_rd && |hit_lo && !mem_if.wr_en) ##1 (clk_en && !mem_if.wr_en)
        |=> reg_rdata[7:4] == shadow[$past(rd_slot_q)][DMR_NIB_LSB-1:0])
        else $error("low register nibble not from stored result");

    a_subst_refresh: assert property (@(posedge clk) disable iff (!reset_n) // R4
        (temperature_value_substitute && !src_frozen && !src_valid)
        |-> mem_if.wr_en && mem_if.wr_idx == DMR_SLOT_TEMP
            && mem_if.wr_data == temp_substitute_data)
        else $error("temperature slot not refreshed from substitute");
endmodule : dmr_readback_bank
`default_nettype wire

// [hdl/dmr_result_store.sv]
// small store of the 12-bit monitor results, one word per channel slot.
// assumes a single clock; read data come out of a register one edge later.
`timescale 1ns/100ps
`default_nettype none
module dmr_result_store
    import dmr_pkg::*;
#(
    parameter int DEPTH = DMR_SLOTS
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // access
    dmr_mem_if.store mem
);
    logic [DMR_RW-1:0] word [DEPTH];

    // one whole word per write keeps byte and nibble coherent
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                word[i] <= DMR_RESULT_RESET;
            end
        end else if (clk_en && mem.wr_en) begin
            word[mem.wr_idx] <= mem.wr_data;
        end
    end

    // registered read port
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem.rd_data <= DMR_RESULT_RESET;
        end else if (clk_en && mem.rd_en) begin
            mem.rd_data <= word[mem.rd_idx];
        end
    end
endmodule : dmr_result_store
`default_nettype wire

// [verif/dmr_readback_bank_test.sv]
// self-checking bench for the diagnostic monitor readback bank.
// assumes the bank answers reads two enabled edges after the strobe.
`timescale 1ns/100ps
`default_nettype none
module dmr_readback_bank_test;
    import dmr_pkg::*;

    logic clk, reset_n, clk_en, reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic conv_valid, aux_valid;
    logic [3:0] conv_channel, aux_channel;
    logic [11:0] conv_data, aux_data, temp_substitute_data;
    logic frz, subst, aux_frz, route;
    integer errors = 0;
    integer checks_done = 0;
    integer seed = 95299;
    // reference model: one word per slot plus the four control bits
    logic [11:0] st [7];
    logic [3:0] ctl;
    // map kept apart from the package so a wrong constant there shows up
    logic [7:0] hi_ofs [7] = '{8'h58, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6a, 8'h6c};
    logic [7:0] lo_ofs [7] = '{8'h59, 8'h63, 8'h65, 8'h67, 8'h69, 8'h6b, 8'h6d};
    logic [3:0] code [7] = '{4'h1, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};

    dmr_readback_bank dut (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
        .aux_valid(aux_valid), .aux_channel(aux_channel), .aux_data(aux_data),
        .temp_substitute_data(temp_substitute_data),
        .freeze_converter_readback(frz), .temperature_value_substitute(subst),
        .freeze_aux_converter_readback(aux_frz), .route_aux_converter_to_monitor(route)
    );

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // expected byte of any address, from the model
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        exp_reg = (a == 8'h55) ? {4'h0, ctl} : 8'h00;
        for (int i = 0; i < 7; i++) begin
            if (a == hi_ofs[i]) exp_reg = st[i][11:4];
            if (a == lo_ofs[i]) exp_reg = {st[i][3:0], code[i]};
        end
    endfunction : exp_reg

    // one read; the expectation is fixed before the strobe is driven
    task automatic rd(input logic [7:0] a);
        logic [7:0] exp;
        int n;
        exp = exp_reg(a);
        n = 0;
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        while (reg_rvalid !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (reg_rvalid !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: no read answer", $time);
            give_verdict();
        end
        check(reg_rdata, exp);
    endtask : rd

    task automatic rd_all;
        for (int a = 8'h54; a <= 8'h6e; a++) begin
            rd(8'(a));
        end
    endtask : rd_all

    // one write; control outputs must follow on the next cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        if (a == 8'h55) ctl = d[3:0];
        if (ctl[1] && !(ctl[3] ? ctl[2] : ctl[0])) st[5] = temp_substitute_data;
        check({4'h0, route, aux_frz, subst, frz}, {4'h0, ctl});
    endtask : wr

    // one result strobe from either converter, optionally with the clock disabled
    task automatic conv(input logic aux, input logic [3:0] ch, input logic en);
        logic [11:0] d;
        d = 12'($random(seed));
        @(negedge clk);
        clk_en = en;
        if (aux) begin
            aux_valid = 1'b1;
            aux_channel = ch;
            aux_data = d;
        end else begin
            conv_valid = 1'b1;
            conv_channel = ch;
            conv_data = d;
        end
        @(negedge clk);
        conv_valid = 1'b0;
        aux_valid = 1'b0;
        clk_en = 1'b1;
        if (en && aux == ctl[3] && !(aux ? ctl[2] : ctl[0])) begin
            for (int i = 0; i < 7; i++) begin
                if (code[i] == ch) st[i] = (i == 5 && ctl[1]) ? temp_substitute_data : d;
            end
        end
    endtask : conv

    task automatic burst(input logic aux);
        for (int i = 0; i < 7; i++) begin
            conv(aux, code[i], 1'b1);
        end
    endtask : burst

    initial begin
        {reset_n, reg_wr, reg_rd, conv_valid, aux_valid} = '0;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        {conv_channel, aux_channel} = '0;
        {conv_data, aux_data} = '0;
        temp_substitute_data = 12'($random(seed));
        ctl = 4'h0;
        for (int i = 0; i < 7; i++) st[i] = 12'h000;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        // reset values, channel codes and unmapped places
        check({4'h0, route, aux_frz, subst, frz}, 8'h00);
        rd_all();
        $display("test reset done");
        // reserved control bits and writes to read-only places
        wr(8'h55, 8'hff);
        rd(8'h55);
        wr(8'h55, 8'h00);
        wr(8'h58, 8'hff);
        wr(8'h59, 8'hff);
        rd(8'h58);
        rd(8'h59);
        $display("test control done");
        // fresh results in every slot, an unknown channel and a stalled clock
        burst(1'b0);
        conv(1'b0, 4'h2, 1'b1);
        conv(1'b0, 4'h1, 1'b0);
        rd_all();
        $display("test results done");
        // freeze holds both halves; release resumes with the next result
        wr(8'h55, 8'h01);
        burst(1'b0);
        burst(1'b1);
        rd_all();
        wr(8'h55, 8'h00);
        burst(1'b0);
        rd_all();
        $display("test freeze done");
        // auxiliary routing and its own freeze
        wr(8'h55, 8'h08);
        burst(1'b0);
        burst(1'b1);
        rd_all();
        wr(8'h55, 8'h0c);
        burst(1'b1);
        rd_all();
        wr(8'h55, 8'h08);
        burst(1'b1);
        rd_all();
        wr(8'h55, 8'h00);
        $display("test route done");
        // temperature substitute
        wr(8'h55, 8'h02);
        conv(1'b0, 4'ha, 1'b1);
        conv(1'b0, 4'h1, 1'b1);
        rd_all();
        wr(8'h55, 8'h00);
        conv(1'b0, 4'ha, 1'b1);
        rd(8'h6a);
        rd(8'h6b);
        $display("test substitute done");
        give_verdict();
    end
endmodule : dmr_readback_bank_test
`default_nettype wire
